/* File: logic/lmc_defines.vh */
// lmc_defines.vh: constants for the lin/uart mode control block
// assumes inclusion by its bare name from the design file
`ifndef LMC_DEFINES_VH
`define LMC_DEFINES_VH
`define LMC_DIV_W        16
`define LMC_TO_W         16
`define LMC_CNT_ZERO     16'h0000
`define LMC_CNT_ONE      16'h0001
`define LMC_BREAK_BITS   4'hd
`define LMC_BIT_ONE      4'h1
`define LMC_BIT_TWO      4'h2
`define LMC_BIT_ZERO     4'h0
`define LMC_DATA_BITS    4'h8
`define LMC_SYNC_BYTE    8'h55
`define LMC_TO_MODE_LIN  1'b0
`define LMC_TO_MODE_OC   1'b1
`define LMC_ST_IDLE      4'h0
`define LMC_ST_BREAK     4'h1
`define LMC_ST_DELIM     4'h2
`define LMC_ST_SYNC      4'h3
`define LMC_ST_PID       4'h4
`define LMC_ST_DATA      4'h5
`define LMC_ST_ZERO      4'h0
`define LMC_FIFO_W       8
`define LMC_FIFO_D       32
`define LMC_FIFO_AW      5
`endif

/* File: logic/lmc_mode_control.v */
// lmc_mode_control.v: lin/uart mode control with a transmit fifo
// assumes software-driven configuration ports synchronous to clock
`timescale 1ns/1ps
`default_nettype none
`include "lmc_defines.vh"

module lmc_fifo #(
	parameter W  = 8,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire          clock,
	input  wire          rst_n,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data,
	output wire          full,
	output wire          empty
);
	reg [W-1:0] mem [0:D-1];
	reg [AW:0]  wp_q;
	reg [AW:0]  rp_q;
	wire        wr;
	wire        rd;
	assign empty     = (wp_q == rp_q);
	assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rp_q[AW-1:0]];
	assign wr        = in_valid & ~full;
	assign rd        = out_ready & ~empty;
	always @(posedge clock) begin
		if (wr)
			mem[wp_q[AW-1:0]] <= in_data;
	end
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (wr)
				wp_q <= wp_q + 1'b1;
			if (rd)
				rp_q <= rp_q + 1'b1;
		end
	end
endmodule

module lmc_mode_control (
	// clock and reset
	input  wire                  clock,
	input  wire                  rst_n,
	// mode configuration
	input  wire                  lin_mode,
	input  wire                  uart_fifo_mode,
	input  wire                  two_bit_delimiter_sel,
	input  wire                  idle_on_timeout,
	input  wire                  timeout_mode,
	input  wire [`LMC_TO_W-1:0]  timeout_limit,
	input  wire [`LMC_DIV_W-1:0] bit_div,
	input  wire                  rx_data_irq_en,
	input  wire                  tx_data_irq_en,
	// header request and data stream
	input  wire                  header_req,
	input  wire [7:0]            header_pid,
	input  wire                  tx_valid,
	output wire                  tx_ready,
	input  wire [7:0]            tx_data,
	// receive side events
	input  wire                  rx_byte_valid,
	input  wire                  rx_break_det,
	input  wire                  rx_fifo_empty,
	// serial line
	output reg                   lin_tx,
	// status
	output wire [3:0]            lin_state_field,
	output wire                  rx_fifo_empty_flag,
	output wire                  tx_fifo_full_flag,
	output reg                   timeout_event,
	output reg                   rx_data_irq,
	output reg                   tx_data_irq,
	output wire                  header_busy
);
	reg [3:0]             st_q;
	reg [3:0]             st_d;
	reg [`LMC_DIV_W-1:0]  div_q;
	reg [3:0]             bits_q;
	reg [9:0]             sh_q;
	reg [`LMC_TO_W-1:0]   to_q;
	wire                  tick;
	wire                  bit_end;
	wire                  f_valid;
	wire                  f_full;
	wire                  f_empty;
	wire [7:0]            f_data;
	wire                  f_take;
	wire                  in_frame;
	wire                  to_hit;
	wire                  force_idle;
	wire                  irq_ok;

	assign tick     = (div_q == `LMC_CNT_ZERO);
	assign bit_end  = tick && (bits_q == `LMC_BIT_ONE);
	assign in_frame = lin_mode && (st_q != `LMC_ST_IDLE);
	assign to_hit   = in_frame && (to_q == timeout_limit);
	// only lin timeout mode may pull the machine back to idle
	assign force_idle = to_hit && idle_on_timeout && (timeout_mode == `LMC_TO_MODE_LIN);
	// pop exactly when a queued byte is loaded into the shifter, so none is sent twice
	assign f_take   = bit_end && f_valid && (st_d == `LMC_ST_DATA) &&
	                  ((st_q == `LMC_ST_PID) || (st_q == `LMC_ST_DATA));

	lmc_fifo #(
		.W  (`LMC_FIFO_W),
		.D  (`LMC_FIFO_D),
		.AW (`LMC_FIFO_AW)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   (tx_data),
		.out_valid (f_valid),
		.out_ready (f_take),
		.out_data  (f_data),
		.full      (f_full),
		.empty     (f_empty)
	);

	always @* begin
		st_d = st_q;
		case (st_q)
			`LMC_ST_IDLE:  if (lin_mode && header_req) st_d = `LMC_ST_BREAK;
			`LMC_ST_BREAK: if (bit_end) st_d = `LMC_ST_DELIM;
			`LMC_ST_DELIM: if (bit_end) st_d = `LMC_ST_SYNC;
			`LMC_ST_SYNC:  if (bit_end) st_d = `LMC_ST_PID;
			`LMC_ST_PID:   if (bit_end) st_d = f_valid ? `LMC_ST_DATA : `LMC_ST_IDLE;
			`LMC_ST_DATA:  if (bit_end && !f_valid) st_d = `LMC_ST_IDLE;
			default:       st_d = `LMC_ST_IDLE;
		endcase
		// a fresh header in any frame state other than idle and identifier restarts identifier transmission
		if (in_frame && rx_break_det)
			st_d = `LMC_ST_PID;
		if (force_idle || !lin_mode)
			st_d = `LMC_ST_IDLE;
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= `LMC_ST_IDLE;
			div_q  <= `LMC_CNT_ZERO;
			bits_q <= `LMC_BIT_ZERO;
			sh_q   <= 10'h3ff;
			lin_tx <= 1'b1;
			to_q   <= `LMC_CNT_ZERO;
			timeout_event <= 1'b0;
			rx_data_irq   <= 1'b0;
			tx_data_irq   <= 1'b0;
		end else begin
			st_q <= st_d;
			timeout_event <= to_hit;
			if (!in_frame || to_hit || st_d != st_q)
				to_q <= `LMC_CNT_ZERO;
			else
				to_q <= to_q + `LMC_CNT_ONE;
			if (st_d != st_q) begin
				div_q <= bit_div;
				case (st_d)
					`LMC_ST_BREAK: begin
						bits_q <= `LMC_BREAK_BITS;
						sh_q   <= 10'h000;
					end
					`LMC_ST_DELIM: begin
						// delimiter length follows the select bit
						bits_q <= two_bit_delimiter_sel ? `LMC_BIT_TWO : `LMC_BIT_ONE;
						sh_q   <= 10'h3ff;
					end
					`LMC_ST_SYNC: begin
						bits_q <= `LMC_DATA_BITS + `LMC_BIT_TWO;
						sh_q   <= {1'b1, `LMC_SYNC_BYTE, 1'b0};
					end
					`LMC_ST_PID: begin
						bits_q <= `LMC_DATA_BITS + `LMC_BIT_TWO;
						sh_q   <= {1'b1, header_pid, 1'b0};
					end
					`LMC_ST_DATA: begin
						bits_q <= `LMC_DATA_BITS + `LMC_BIT_TWO;
						sh_q   <= {1'b1, f_data, 1'b0};
					end
					default: begin
						bits_q <= `LMC_BIT_ZERO;
						sh_q   <= 10'h3ff;
					end
				endcase
			end else if (tick) begin
				div_q <= bit_div;
				if (bits_q != `LMC_BIT_ZERO)
					bits_q <= bits_q - `LMC_BIT_ONE;
				if (bit_end && st_q == `LMC_ST_DATA && f_valid) begin
					// chain the next queued byte without a gap
					bits_q <= `LMC_DATA_BITS + `LMC_BIT_TWO;
					sh_q   <= {1'b1, f_data, 1'b0};
				end else if (st_q != `LMC_ST_BREAK && st_q != `LMC_ST_DELIM)
					sh_q <= {1'b1, sh_q[9:1]};
			end else
				div_q <= div_q - `LMC_CNT_ONE;
			lin_tx <= (st_q == `LMC_ST_IDLE) ? 1'b1 : sh_q[0];
			rx_data_irq <= irq_ok && rx_data_irq_en && rx_byte_valid;
			tx_data_irq <= irq_ok && tx_data_irq_en && f_take;
		end
	end

	// in uart mode, fifo mode disables the data interrupts regardless of the enables
	assign irq_ok = lin_mode || !uart_fifo_mode;
	assign lin_state_field    = lin_mode ? st_q : `LMC_ST_ZERO;
	assign rx_fifo_empty_flag = !lin_mode && uart_fifo_mode && rx_fifo_empty;
	assign tx_fifo_full_flag  = !lin_mode && uart_fifo_mode && f_full;
	assign header_busy        = in_frame && !f_empty;
endmodule
`default_nettype wire

/* File: verification/lmc_chk.sv */
// lmc_chk.sv: port assertions for the mode control block
// assumes binding into lmc_mode_control
`timescale 1ns/1ps
`default_nettype none
module lmc_chk (
	// clock, reset and configuration
	input wire logic       clock, rst_n, lin_mode, uart_fifo_mode, idle_on_timeout, timeout_mode,
	// events and outputs
	input wire logic       header_req, rx_break_det, lin_tx, timeout_event, rx_data_irq,
	input wire logic [3:0] lin_state_field
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	property p_uart; !lin_mode |-> lin_state_field == 4'h0; endproperty
	a_uart: assert property (p_uart) else $error("uart state");
	property p_hdr; lin_mode && header_req && lin_state_field == 4'h0
		|=> lin_state_field == 4'h1 ##1 !lin_tx; endproperty
	a_hdr: assert property (p_hdr) else $error("header start");
	property p_low; lin_state_field == 4'h1 |=> !lin_tx; endproperty
	a_low: assert property (p_low) else $error("break level");
	property p_dhi; lin_state_field == 4'h2 |=> lin_tx; endproperty
	a_dhi: assert property (p_dhi) else $error("delimiter level");
	property p_iot; timeout_event && idle_on_timeout && !timeout_mode |-> lin_state_field == 4'h0; endproperty
	a_iot: assert property (p_iot) else $error("no idle");
	property p_oc; lin_mode && timeout_event && timeout_mode |-> lin_state_field != 4'h0; endproperty
	a_oc: assert property (p_oc) else $error("idle in compare");
	property p_pid; lin_mode && rx_break_det && lin_state_field != 4'h0 |=> lin_state_field == 4'h4; endproperty
	a_pid: assert property (p_pid) else $error("no pid");
	property p_irq; !lin_mode && uart_fifo_mode |=> !rx_data_irq; endproperty
	a_irq: assert property (p_irq) else $error("fifo irq");
endmodule
bind lmc_mode_control lmc_chk u_chk (.*);
`default_nettype wire

/* File: verification/lmc_peer.sv */
// lmc_peer.sv: far-side node giving receive events
// assumes the bench commands each event a cycle ahead
`timescale 1ns/1ps
`default_nettype none
module lmc_peer (
	input  wire logic clock, rst_n, send_byte, send_break,
	output var  logic rx_byte_valid, rx_break_det, rx_fifo_empty
);
	// bytes stay unread, so the receive fifo never empties again
	always @(posedge clock or negedge rst_n)
		if (!rst_n) begin
			rx_byte_valid <= 1'b0;
			rx_break_det <= 1'b0;
			rx_fifo_empty <= 1'b1;
		end else begin
			rx_byte_valid <= send_byte;
			rx_break_det <= send_break;
			rx_fifo_empty <= rx_fifo_empty & ~send_byte;
		end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// tb_top.sv: scenario bench for the mode control block
// assumes the peer model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock = 0, rst_n = 0, lin_mode = 0, uart_fifo_mode = 1, header_req = 0;
	logic        two_bit_delimiter_sel = 0, idle_on_timeout = 1, timeout_mode = 0;
	logic        tx_valid = 0, rx_data_irq_en = 1, tx_data_irq_en = 1, send_byte = 0, send_break = 0;
	logic [15:0] timeout_limit = 16'hffff, bit_div = 16'h0001;
	logic [7:0]  header_pid = 8'h2a, tx_data = 8'h00;
	wire         tx_ready, rx_byte_valid, rx_break_det, rx_fifo_empty, lin_tx, header_busy;
	wire         rx_fifo_empty_flag, tx_fifo_full_flag, timeout_event, rx_data_irq, tx_data_irq;
	wire   [3:0] lin_state_field;
	int          bad_count = 0, checked = 0, n, k;
	logic [19:0] frm;
	always #12.5 clock = ~clock;
	lmc_mode_control dut (.*);
	lmc_peer peer (.*);
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task chk(input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait on line level, idle state or timeout event
	task wt(input logic v, input int s);
		n = 0;
		while ((s == 0 ? lin_tx : s == 1 ? lin_state_field == 4'h0 : timeout_event) !== v) begin
			cyc(1);
			n++;
			if (n > 2000) begin
				bad_count++;
				summarize;
			end
		end
	endtask
	task go;
		header_req = 1;
		cyc(1);
		header_req = 0;
	endtask
	task irq(input logic e);
		send_byte = 1;
		cyc(1);
		send_byte = 0;
		cyc(1);
		chk(rx_data_irq, e);
	endtask
	task t_uart;
		go;
		chk(lin_state_field, 16'h0000);
		chk(rx_fifo_empty_flag, 16'h0001);
		irq(0);
		rx_data_irq_en = 0;
		tx_data_irq_en = 0;
		irq(0);
		rx_data_irq_en = 1;
		tx_data_irq_en = 1;
		chk(rx_fifo_empty_flag, 16'h0000);
		tx_valid = 1;
		for (int i = 0; i < 32; i++) begin
			chk(tx_ready, 16'h0001);
			tx_data = i[7:0];
			cyc(1);
		end
		tx_valid = 0;
		chk(tx_fifo_full_flag, 16'h0001);
		uart_fifo_mode = 0;
		irq(1);
		chk(tx_fifo_full_flag, 16'h0000);
	endtask
	task t_hdr(input logic s);
		two_bit_delimiter_sel = s;
		go;
		chk(lin_state_field, 16'h0001);
		chk(header_busy, s ? 16'h0000 : 16'h0001);
		wt(0, 0);
		wt(1, 0);
		chk(n[15:0], 16'h001a);
		wt(0, 0);
		chk(n[15:0], s ? 16'h0004 : 16'h0002);
		// sync and identifier sampled once per two-cycle bit, data irqs counted throughout
		k = 0;
		for (int i = 0; i < 40; i++) begin
			if (!i[0])
				frm[i >> 1] = lin_tx;
			k = k + tx_data_irq;
			cyc(1);
		end
		chk(frm[9:0], 16'h02aa);
		chk(frm[19:10], 16'h0254);
		n = 0;
		while (lin_state_field != 4'h0 && n < 2000) begin
			k = k + tx_data_irq;
			cyc(1);
			n++;
		end
		chk(n < 2000, 16'h0001);
		chk(k[15:0], s ? 16'h0000 : 16'h0020);
		chk(tx_ready, 16'h0001);
	endtask
	task t_to(input logic m);
		timeout_mode = m;
		go;
		cyc(2);
		send_break = 1;
		cyc(1);
		send_break = 0;
		cyc(1);
		chk(lin_state_field, 16'h0004);
		wt(1, 2);
		chk(n > 7 && n < 14, 16'h0001);
		chk(lin_state_field, m ? 16'h0004 : 16'h0000);
		lin_mode = 0;
		cyc(1);
		lin_mode = 1;
	endtask
	initial begin
		cyc(12);
		rst_n = 1;
		cyc(1);
		t_uart;
		lin_mode = 1;
		irq(1);
		t_hdr(0);
		t_hdr(1);
		timeout_limit = 16'h000a;
		t_to(0);
		t_to(1);
		summarize;
	end
endmodule
`default_nettype wire
